// ===== shared/sf_pkg.sv
// Purpose: Shared constants and types for the semaphore-flag port controller
// Assumes: One port of a dual-port RAM with eight semaphore flags, 200 MHz clock
// Notes:   Pin timing figures are plain defaults, tune to the attached part
//
// Behaviour
// - Semaphore space reached with select low
// - Write zero requests, write one releases
// - Drop select between polling reads
// - Write zero first, then read back
// - Failed request: keep reading or withdraw
// - Software frees all flags at start
// - Array select high during semaphore access
package sf_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int unsigned DQ_W        = 18;
   localparam int unsigned ADDR_W      = 13;
   localparam int unsigned IDX_W       = 3;
   localparam int unsigned FLAG_COUNT  = 8;
   localparam int unsigned CNT_W       = 4;
   localparam int unsigned SYNC_STAGES = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Timing in ns and derived cycle counts (least times round up)
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned T_SETUP_NS    = 5;
   localparam int unsigned T_WE_NS       = 15;
   localparam int unsigned T_ACC_NS      = 20;
   localparam int unsigned T_GAP_NS      = 10;
   localparam int unsigned SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WE_CYC    = (T_WE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned ACC_CYC   = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned GAP_CYC   = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // Commands from the user side
   typedef enum logic [1:0] {
      OP_READ    = 2'h0,
      OP_CLAIM   = 2'h1,
      OP_RELEASE = 2'h2,
      OP_INIT    = 2'h3
   } sf_op_e;

   typedef struct packed {
      sf_op_e           op;
      logic [IDX_W-1:0] flag;
      logic             wait_grant; // Claim keeps polling instead of withdrawing
   } sf_cmd_s;

   typedef struct packed {
      logic granted;    // Claim succeeded
      logic flag_level; // Level last read from the flag
   } sf_rsp_s;

   // Pins toward the device port
   typedef struct packed {
      logic              sem_n;
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0]   dq_out;
      logic              dq_oe;
   } sf_pins_s;

   localparam sf_pins_s PINS_IDLE = '{sem_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                      addr: 13'h0000, dq_out: 18'h0_0000, dq_oe: 1'b0};

   ////////////////////////////////////////////////////////////////////////////
   // Controller states
   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_WSET  = 6'h02,
      ST_WSTRB = 6'h04,
      ST_WEND  = 6'h08,
      ST_RACC  = 6'h10,
      ST_RGAP  = 6'h20
   } sf_state_e;

endpackage

// ===== hdl/sf_sync.sv
// Purpose: Two-stage synchroniser for the data pins read back from the device
// Assumes: Inputs are asynchronous to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module sf_sync #(
   parameter int unsigned WIDTH = 18
) (
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;

   // Two flip-flops in series
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta     <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule // sf_sync

// ===== hdl/sf_port_ctrl.sv
// Purpose: Drives one port of a dual-port RAM's semaphore flags from user commands
// Assumes: The device keeps its own flag and request-latch logic
// Notes:   Claim writes zero then reads back; a lost claim polls or withdraws
`timescale 1ns/1ps
module sf_port_ctrl #(
   parameter int unsigned SETUP_CYC = sf_pkg::SETUP_CYC,
   parameter int unsigned WE_CYC    = sf_pkg::WE_CYC,
   parameter int unsigned ACC_CYC   = sf_pkg::ACC_CYC,
   parameter int unsigned GAP_CYC   = sf_pkg::GAP_CYC
) (
   input  wire logic                    clk,
   input  wire logic                    arst_n,
   input  wire logic                    cmd_valid,
   input  wire sf_pkg::sf_cmd_s         cmd,
   output logic                         cmd_ready,
   output logic                         rsp_valid,
   output sf_pkg::sf_rsp_s              rsp,
   output sf_pkg::sf_pins_s             pins,
   input  wire logic [sf_pkg::DQ_W-1:0] dq_in
);

   localparam logic [sf_pkg::CNT_W-1:0] C_SETUP = sf_pkg::CNT_W'(SETUP_CYC);
   localparam logic [sf_pkg::CNT_W-1:0] C_WE    = sf_pkg::CNT_W'(WE_CYC);
   localparam logic [sf_pkg::CNT_W-1:0] C_READ  = sf_pkg::CNT_W'(ACC_CYC + sf_pkg::SYNC_STAGES);
   localparam logic [sf_pkg::CNT_W-1:0] C_GAP   = sf_pkg::CNT_W'(GAP_CYC);

   // Flag index onto the address pins, upper lines held at zero
   function automatic logic [sf_pkg::ADDR_W-1:0] flag_addr(input logic [sf_pkg::IDX_W-1:0] i);
      flag_addr = {{(sf_pkg::ADDR_W - sf_pkg::IDX_W){1'b0}}, i};
   endfunction

   sf_pkg::sf_state_e            st;
   sf_pkg::sf_state_e            next_st;
   logic [sf_pkg::CNT_W-1:0]     cnt;
   logic [sf_pkg::CNT_W-1:0]     next_cnt;
   sf_pkg::sf_op_e               op;
   sf_pkg::sf_op_e               next_op;
   logic [sf_pkg::IDX_W-1:0]     idx;
   logic [sf_pkg::IDX_W-1:0]     next_idx;
   logic                         wt;
   logic                         next_wt;
   logic                         wval;
   logic                         next_wval;
   logic                         level;
   logic                         next_level;
   sf_pkg::sf_pins_s             next_pins;
   logic                         next_cmd_ready;
   logic                         next_rsp_valid;
   sf_pkg::sf_rsp_s              next_rsp;
   logic [sf_pkg::DQ_W-1:0]      dq_sync;

   ////////////////////////////////////////////////////////////////////////////
   // Read-back data through two flip-flops
   sf_sync #(.WIDTH(sf_pkg::DQ_W)) u_sync (
      .clk      (clk),
      .arst_n   (arst_n),
      .async_in (dq_in),
      .sync_out (dq_sync)
   );

   // Named decode terms
   wire logic take     = cmd_valid && cmd_ready;
   wire logic cnt_done = (cnt <= sf_pkg::CNT_W'(1));
   wire logic cnt_dec  = ~cnt_done;
   wire logic last_idx = (idx == sf_pkg::IDX_W'(sf_pkg::FLAG_COUNT - 1));

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_comb
   begin
      next_st        = st;
      next_cnt       = cnt_dec ? cnt - sf_pkg::CNT_W'(1) : cnt;
      next_op        = op;
      next_idx       = idx;
      next_wt        = wt;
      next_wval      = wval;
      next_level     = level;
      next_pins      = pins;
      next_cmd_ready = cmd_ready;
      next_rsp_valid = 1'b0;
      next_rsp       = rsp;
      case (st)
         sf_pkg::ST_IDLE:
         begin
            if (take)
            begin
               next_op        = cmd.op;
               next_wt        = cmd.wait_grant;
               next_idx       = (cmd.op == sf_pkg::OP_INIT) ? '0 : cmd.flag;
               next_wval      = (cmd.op != sf_pkg::OP_CLAIM);
               next_cmd_ready = 1'b0;
               next_pins.ce_n = 1'b1;
               next_pins.sem_n = 1'b0;
               next_pins.addr = flag_addr((cmd.op == sf_pkg::OP_INIT) ? '0 : cmd.flag);
               if (cmd.op == sf_pkg::OP_READ)
               begin
                  next_pins.oe_n = 1'b0;
                  next_cnt       = C_READ;
                  next_st        = sf_pkg::ST_RACC;
               end
               else
               begin
                  next_pins.dq_out = {sf_pkg::DQ_W{cmd.op != sf_pkg::OP_CLAIM}};
                  next_pins.dq_oe  = 1'b1;
                  next_cnt         = C_SETUP;
                  next_st          = sf_pkg::ST_WSET;
               end
            end
         end
         sf_pkg::ST_WSET:
         begin
            if (cnt_done)
            begin
               next_pins.we_n = 1'b0;
               next_cnt       = C_WE;
               next_st        = sf_pkg::ST_WSTRB;
            end
         end
         sf_pkg::ST_WSTRB:
         begin
            // Strobe and select rise together, data held past the edge
            if (cnt_done)
            begin
               next_pins.we_n  = 1'b1;
               next_pins.sem_n = 1'b1;
               next_cnt        = C_GAP;
               next_st         = sf_pkg::ST_WEND;
            end
         end
         sf_pkg::ST_WEND:
         begin
            if (cnt_done)
            begin
               next_pins.dq_oe = 1'b0;
               if (op == sf_pkg::OP_CLAIM && !wval)
               begin
                  // Read back only after the zero was written
                  next_pins.sem_n = 1'b0;
                  next_pins.oe_n  = 1'b0;
                  next_cnt        = C_READ;
                  next_st         = sf_pkg::ST_RACC;
               end
               else if (op == sf_pkg::OP_INIT && !last_idx)
               begin
                  next_idx         = idx + sf_pkg::IDX_W'(1);
                  next_pins.addr   = flag_addr(idx + sf_pkg::IDX_W'(1));
                  next_pins.sem_n  = 1'b0;
                  next_pins.dq_oe  = 1'b1;
                  next_cnt         = C_SETUP;
                  next_st          = sf_pkg::ST_WSET;
               end
               else
               begin
                  next_rsp_valid   = 1'b1;
                  next_rsp.granted = 1'b0;
                  next_cmd_ready   = 1'b1;
                  next_st          = sf_pkg::ST_IDLE;
               end
            end
         end
         sf_pkg::ST_RACC:
         begin
            // Sample after access time plus synchroniser delay, then drop select
            if (cnt_done)
            begin
               next_level      = dq_sync[0];
               next_pins.sem_n = 1'b1;
               next_pins.oe_n  = 1'b1;
               next_cnt        = C_GAP;
               next_st         = sf_pkg::ST_RGAP;
            end
         end
         sf_pkg::ST_RGAP:
         begin
            if (cnt_done)
            begin
               if (op == sf_pkg::OP_CLAIM && level && wt)
               begin
                  // Lost, keep polling with select toggled between reads
                  next_pins.sem_n = 1'b0;
                  next_pins.oe_n  = 1'b0;
                  next_cnt        = C_READ;
                  next_st         = sf_pkg::ST_RACC;
               end
               else if (op == sf_pkg::OP_CLAIM && level)
               begin
                  // Lost, withdraw the pending request by writing one
                  next_wval        = 1'b1;
                  next_pins.sem_n  = 1'b0;
                  next_pins.dq_out = {sf_pkg::DQ_W{1'b1}};
                  next_pins.dq_oe  = 1'b1;
                  next_cnt         = C_SETUP;
                  next_st          = sf_pkg::ST_WSET;
               end
               else
               begin
                  next_rsp_valid      = 1'b1;
                  next_rsp.granted    = (op == sf_pkg::OP_CLAIM) && !level;
                  next_rsp.flag_level = level;
                  next_cmd_ready      = 1'b1;
                  next_st             = sf_pkg::ST_IDLE;
               end
            end
         end
         default:
         begin
            next_pins = sf_pkg::PINS_IDLE;
            next_st   = sf_pkg::ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State registers
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st        <= sf_pkg::ST_IDLE;
         cnt       <= '0;
         op        <= sf_pkg::OP_READ;
         idx       <= '0;
         wt        <= 1'b0;
         wval      <= 1'b1;
         level     <= 1'b1;
         pins      <= sf_pkg::PINS_IDLE;
         cmd_ready <= 1'b1;
         rsp_valid <= 1'b0;
         rsp       <= '0;
      end
      else
      begin
         st        <= next_st;
         cnt       <= next_cnt;
         op        <= next_op;
         idx       <= next_idx;
         wt        <= next_wt;
         wval      <= next_wval;
         level     <= next_level;
         pins      <= next_pins;
         cmd_ready <= next_cmd_ready;
         rsp_valid <= next_rsp_valid;
         rsp       <= next_rsp;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checking helpers: count write strobes during an init command
   logic       we_prev;
   logic [3:0] init_writes;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         we_prev     <= 1'b1;
         init_writes <= 4'h0;
      end
      else
      begin
         we_prev     <= pins.we_n;
         init_writes <= take ? 4'h0 : init_writes + 4'((we_prev && !pins.we_n) ? 1 : 0);
      end
   end

   sequence s_claim_taken;
      take && cmd.op == sf_pkg::OP_CLAIM;
   endsequence

   sequence s_write_zero;
      !pins.we_n && !pins.dq_out[0];
   endsequence

   sequence s_write_one;
      !pins.we_n && pins.dq_out[0];
   endsequence

   chk_sem_array_apart: assert property (@(posedge clk) disable iff (!arst_n)
      !pins.sem_n |-> pins.ce_n)
      else $error("array select active during semaphore access");

   chk_write_in_space: assert property (@(posedge clk) disable iff (!arst_n)
      !pins.we_n |-> (!pins.sem_n && pins.oe_n && pins.dq_oe))
      else $error("write strobe outside semaphore space");

   chk_read_no_drive: assert property (@(posedge clk) disable iff (!arst_n)
      !pins.oe_n |-> !pins.dq_oe)
      else $error("data driven while reading");

   chk_read_fresh_sel: assert property (@(posedge clk) disable iff (!arst_n)
      $fell(pins.oe_n) |-> $fell(pins.sem_n))
      else $error("read started without select toggle");

   chk_claim_zero_first: assert property (@(posedge clk) disable iff (!arst_n)
      s_claim_taken |-> pins.oe_n [*3] ##1 (s_write_zero))
      else $error("claim did not write zero before reading");

   chk_release_writes_one: assert property (@(posedge clk) disable iff (!arst_n)
      take && cmd.op == sf_pkg::OP_RELEASE |-> ##3 s_write_one)
      else $error("release did not write one");

   chk_lost_withdraws: assert property (@(posedge clk) disable iff (!arst_n)
      (st == sf_pkg::ST_RGAP && cnt_done && op == sf_pkg::OP_CLAIM && level && !wt)
      |-> ##1 pins.oe_n [*2] ##1 s_write_one)
      else $error("lost claim not withdrawn");

   chk_init_all_flags: assert property (@(posedge clk) disable iff (!arst_n)
      (rsp_valid && op == sf_pkg::OP_INIT) |-> (init_writes == 4'h8 && idx == 3'h7))
      else $error("init did not free all eight flags");

endmodule // sf_port_ctrl

// ===== dv/sf_sem_model.sv
// Purpose: Model of the device's eight semaphore flags seen from two ports
// Assumes: Port 0 faces the controller, port 1 is driven by the bench
// Notes:   Starts owned by port 1 with port 0 pending; only software frees it
`timescale 1ns/1ps
module sf_sem_model (
   input  wire logic [1:0]       sem_n,
   input  wire logic [1:0]       oe_n,
   input  wire logic [1:0]       we_n,
   input  wire logic [1:0][2:0]  idx,
   input  wire logic [1:0]       d0,
   output wire logic [1:0][17:0] dq
);
   ////////////////////////////////////////////////////////////////////////////
   // Flag state, kept apart from memory and gating nothing
   logic [7:0] held  = 8'hff;
   logic [7:0] owner = 8'hff;
   logic [7:0] req [2] = '{8'h00, 8'h00};

   // Request latch update and hand-over for one committed write
   task automatic commit(input int s, input logic [2:0] i, input logic v);
      req[s][i] = v;
      if (!v && !held[i])
      begin
         held[i]  = 1'b1;
         owner[i] = s[0];
      end
      else if (v && held[i] && owner[i] == s[0])
      begin
         if (!req[1-s][i])
            owner[i] = ~s[0];
         else
            held[i] = 1'b0;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   for (genvar s = 0; s < 2; s++)
   begin : g_side
      logic wr_n;
      logic rd_n;
      logic wr_last = 1'b1;
      logic rd_last = 1'b1;
      logic lat     = 1'b1;
      assign wr_n = sem_n[s] | we_n[s];
      assign rd_n = sem_n[s] | oe_n[s];
      // Write commits as the strobe returns high
      always @(wr_n)
      begin
         if (wr_n === 1'b1 && wr_last === 1'b0)
            commit(s, idx[s], d0[s]);
         wr_last = wr_n;
      end
      // Output latch loads as select and output enable go active
      always @(rd_n)
      begin
         if (rd_n === 1'b0 && rd_last === 1'b1)
            lat = ~(held[idx[s]] && owner[idx[s]] == s[0]);
         rd_last = rd_n;
      end
      // Flag spread on all bits; a released bus shows the inverse
      assign dq[s] = rd_n ? {18{~lat}} : {18{lat}};
   end
endmodule // sf_sem_model

// ===== dv/dual_port_semaphore_flags_bench.sv
// Purpose: Self-checking bench for the semaphore port controller
// Assumes: Device model on the far side, bench plays the opposite port
// Notes:   Latencies follow the controller's default timing parameters
`timescale 1ns/1ps
module dual_port_semaphore_flags_bench;
   logic                      clk       = 1'b0;
   logic                      arst_n    = 1'b0;
   logic                      cmd_valid = 1'b0;
   sf_pkg::sf_cmd_s           cmd       = '0;
   logic                      cmd_ready;
   logic                      rsp_valid;
   sf_pkg::sf_rsp_s           rsp;
   sf_pkg::sf_pins_s          pins;
   logic [sf_pkg::DQ_W-1:0]   dq_in;
   logic [1:0][17:0]          mdq;
   logic                      r_sem_n   = 1'b1;
   logic                      r_oe_n    = 1'b1;
   logic                      r_we_n    = 1'b1;
   logic                      r_d0      = 1'b1;
   logic [2:0]                r_idx     = 3'h0;
   sf_pkg::sf_rsp_s           got;
   int                        err_total = 0;
   int                        samples_checked = 0;

   // Answer latencies in cycles after the taking edge, from the timing constants
   localparam int W_LAT = sf_pkg::SETUP_CYC + sf_pkg::WE_CYC + sf_pkg::GAP_CYC;
   localparam int R_LAT = sf_pkg::ACC_CYC + sf_pkg::SYNC_STAGES + sf_pkg::GAP_CYC;

   ////////////////////////////////////////////////////////////////////////////
   sf_port_ctrl DUT (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .dq_in(dq_in));
   // Data bus seen by the controller
   assign dq_in = pins.dq_oe ? pins.dq_out : mdq[0];
   sf_sem_model u_dev (.sem_n({r_sem_n, pins.sem_n}), .oe_n({r_oe_n, pins.oe_n}),
      .we_n({r_we_n, pins.we_n}), .idx({r_idx, pins.addr[2:0]}), .d0({r_d0, dq_in[0]}),
      .dq(mdq));

   // Clock and watchdog
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      complete_run();
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One command, timed from the edge that takes it
   task automatic issue(input sf_pkg::sf_op_e op, input logic [2:0] f, input logic wg,
                        input int lat);
      int n;
      n = 0;
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd       <= '{op: op, flag: f, wait_grant: wg};
      @(posedge clk);
      cmd_valid <= 1'b0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
         check("array select", pins.ce_n, 1'b1);
      end while (rsp_valid !== 1'b1 && n < 3000);
      check("answer", rsp_valid, 1'b1);
      got = rsp;
      check("ready at answer", cmd_ready, 1'b1);
      if (lat >= 0)
         check("latency", n, lat);
   endtask

   // Opposite port write and read
   task automatic r_write(input logic [2:0] f, input logic v);
      @(posedge clk);
      r_sem_n <= 1'b0;
      r_idx   <= f;
      r_d0    <= v;
      @(posedge clk);
      r_we_n  <= 1'b0;
      repeat (3) @(posedge clk);
      r_we_n  <= 1'b1;
      r_sem_n <= 1'b1;
   endtask
   task automatic r_read(input logic [2:0] f, output logic [17:0] q);
      @(posedge clk);
      r_sem_n <= 1'b0;
      r_oe_n  <= 1'b0;
      r_idx   <= f;
      repeat (3) @(posedge clk);
      q = mdq[1];
      r_sem_n <= 1'b1;
      r_oe_n  <= 1'b1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Free every flag from both sides, then read each one
   task automatic t_init();
      logic [17:0] q;
      issue(sf_pkg::OP_INIT, 3'h0, 1'b0, sf_pkg::FLAG_COUNT * W_LAT);
      for (int i = 0; i < 8; i++)
         r_write(i[2:0], 1'b1);
      for (int i = 0; i < 8; i++)
      begin
         issue(sf_pkg::OP_READ, i[2:0], 1'b0, R_LAT);
         check("free flag", got.flag_level, 1'b1);
         r_read(i[2:0], q);
         check("free flag far", q, 18'h3_ffff);
      end
      $display("test init done");
   endtask

   // Claim, far request pending, release hands over
   task automatic t_pass();
      logic [17:0] q;
      for (int i = 0; i < 8; i++)
      begin
         issue(sf_pkg::OP_CLAIM, i[2:0], 1'b0, W_LAT + R_LAT);
         check("claim won", got, 2'h2);
         r_read(i[2:0], q);
         check("far sees one", q, 18'h3_ffff);
         r_write(i[2:0], 1'b0);
         @(posedge clk);
         r_sem_n <= 1'b0;
         r_oe_n  <= 1'b0;
         issue(sf_pkg::OP_RELEASE, i[2:0], 1'b0, W_LAT);
         check("held read", mdq[1], 18'h3_ffff);
         @(posedge clk);
         r_sem_n <= 1'b1;
         r_oe_n  <= 1'b1;
         r_read(i[2:0], q);
         check("handed over", q, 18'h0_0000);
         issue(sf_pkg::OP_READ, i[2:0], 1'b0, R_LAT);
         check("owned elsewhere", got.flag_level, 1'b1);
         r_write(i[2:0], 1'b1);
      end
      $display("test pass done");
   endtask

   // Lost claim withdraws its request
   task automatic t_withdraw();
      r_write(3'h4, 1'b0);
      issue(sf_pkg::OP_CLAIM, 3'h4, 1'b0, 2 * W_LAT + R_LAT);
      check("claim lost", got, 2'h1);
      r_write(3'h4, 1'b1);
      issue(sf_pkg::OP_READ, 3'h4, 1'b0, R_LAT);
      check("withdrawn", got.flag_level, 1'b1);
      $display("test withdraw done");
   endtask

   // Polling claim wins once the far side lets go
   task automatic t_poll();
      logic [17:0] q;
      r_write(3'h6, 1'b0);
      fork
         issue(sf_pkg::OP_CLAIM, 3'h6, 1'b1, -1);
         begin
            repeat (60) @(posedge clk);
            r_write(3'h6, 1'b1);
         end
      join
      check("poll won", got, 2'h2);
      r_read(3'h6, q);
      check("poll far", q, 18'h3_ffff);
      issue(sf_pkg::OP_RELEASE, 3'h6, 1'b0, W_LAT);
      $display("test poll done");
   endtask

   // Both sides request together; exactly one wins
   task automatic t_race();
      logic [17:0] q;
      fork
         issue(sf_pkg::OP_CLAIM, 3'h7, 1'b0, -1);
         r_write(3'h7, 1'b0);
      join
      r_read(3'h7, q);
      check("one winner", got.granted ^ q[0], 1'b0);
      r_write(3'h7, 1'b1);
      if (got.granted === 1'b1)
         issue(sf_pkg::OP_RELEASE, 3'h7, 1'b0, W_LAT);
      $display("test race done");
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      #1;
      check("pins idle", pins, sf_pkg::PINS_IDLE);
      t_init();
      t_pass();
      t_withdraw();
      t_poll();
      t_race();
      complete_run();
   end
endmodule // dual_port_semaphore_flags_bench
